/* hdl/rat_pkg.sv */
// package: constants and types of the alarm, interrupt and rate trim block
package rat_pkg;

    // ------------------------------------------------------------------
    // clocking and time base
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned OSC_HZ = 32_768;
    localparam int unsigned ACC_W = 24;
    localparam int unsigned DIV_W = 16;
    localparam logic [DIV_W-1:0] DIV_TERM = 16'h7FFF;
    localparam int unsigned EDGE_TIME_US = 7810;
    // a longest time: rounds down to whole cycles
    localparam int unsigned EDGE_CYCLES =
        (EDGE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned EDGE_W = 17;
    localparam logic [5:0] SEC_LAST = 6'h3B;
    localparam logic [5:0] SEC_HALF = 6'h1E;
    localparam int unsigned CORR_SHORT_S = 20;
    localparam int unsigned CORR_LONG_S = 60;
    localparam logic [5:0] CORR_SHORT_LAST = 6'(CORR_SHORT_S - 1);

    // ------------------------------------------------------------------
    // register map (apb byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS1 = 8'h00;
    localparam logic [7:0] ADDR_STATUS2 = 8'h04;
    localparam logic [7:0] ADDR_ALARM1 = 8'h08;
    localparam logic [7:0] ADDR_ALARM2 = 8'h0C;
    localparam logic [7:0] ADDR_CORR = 8'h10;
    localparam logic [7:0] ADDR_STATE = 8'h14;

    // status register 1 fields
    localparam int unsigned S1_A2_FLAG = 2;
    localparam int unsigned S1_A1_FLAG = 3;
    // status register 2 fields
    localparam int unsigned S2_A1_EN = 0;
    localparam int unsigned S2_A2_OE = 1;
    localparam int unsigned S2_ME = 2;
    localparam int unsigned S2_FE = 3;
    localparam int unsigned S2_MP = 4;
    localparam int unsigned S2_W = 5;
    // setting register: minute [7:0], hour [15:8], day of week [18:16]
    localparam int unsigned SET_W = 19;
    // frequency select bits b7..b3: 1, 2, 4, 8, 16 Hz
    localparam int unsigned FSEL_LO = 3;
    localparam int unsigned FSEL_N = 5;
    // correction register: b0 interval select, b7..b1 bit-reversed code
    localparam int unsigned CORR_W = 8;

    localparam logic [S2_W-1:0] STATUS2_RST = 5'h00;
    localparam logic [SET_W-1:0] SETTING_RST = 19'h00000;
    localparam logic [CORR_W-1:0] CORR_RST = 8'h00;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] dow;
        logic [7:0] hour;
        logic [7:0] minute;
    } rat_time_t;

    typedef struct packed {
        logic sel;
        logic en;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } rat_apb_req_t;

    typedef struct packed {
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } rat_apb_rsp_t;

    typedef enum logic [2:0] {
        RAT_MODE_OFF = 3'b000,
        RAT_MODE_ALARM2 = 3'b001,
        RAT_MODE_FREQ = 3'b010,
        RAT_MODE_EDGE = 3'b011,
        RAT_MODE_PERIOD = 3'b100
    } rat_mode_t;

endpackage : rat_pkg

/* hdl/rat_top.sv */
// alarm compare, second interrupt pin modes and divider rate trim
module rat_top
    import rat_pkg::*;
#(
    parameter int unsigned OSC_INC = rat_pkg::OSC_HZ,
    parameter int unsigned CLK_MOD = rat_pkg::CLK_HZ,
    parameter int unsigned EDGE_LEN = rat_pkg::EDGE_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // running time from the calendar counters
    input rat_pkg::rat_time_t time_now,
    output logic minute_carry,
    output logic second_tick,
    // open-drain second interrupt pin
    output logic second_irq_pin_o,
    output logic second_irq_pin_oe
);
    import rat_pkg::*;

    // ------------------------------------------------------------------
    // registers and internal state
    // ------------------------------------------------------------------
    logic [S2_W-1:0] status2_q;
    logic [SET_W-1:0] alarm1_setting_reg_q, alarm2_setting_reg_q;
    logic [CORR_W-1:0] corr_q;
    logic alarm1_match_flag_q, alarm2_match_flag_q;
    rat_apb_req_t req;
    rat_apb_rsp_t rsp_q;
    logic acc_wr, acc_rd, addr_ok;
    logic [31:0] rd_mux;
    logic [ACC_W-1:0] acc_q;
    logic [DIV_W-1:0] div_q, div_term;
    logic [5:0] sec_q;
    logic osc_tick_q, carry_now, corr_second, edge_active;
    logic [6:0] corr_code;
    logic [EDGE_W-1:0] edge_cnt_q;
    logic alarm1_match, alarm2_match, alarm1_match_q, alarm2_match_q;
    logic alarm2_event, alarm2_low_q, edge_latch_q, period_run_q;
    logic [FSEL_N-1:0] freq_src, freq_sel;
    rat_mode_t mode;
    logic freq_low, pin_low, pin_oe_q, minute_carry_q, second_tick_q;

    // ------------------------------------------------------------------
    // apb slave: one wait state, answer in the second access cycle
    // ------------------------------------------------------------------
    assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr,
                   wdata: pwdata};
    assign acc_wr = req.sel && req.en && rsp_q.ready && req.wr;
    assign acc_rd = req.sel && req.en && rsp_q.ready && !req.wr;
    assign addr_ok = (req.addr == ADDR_STATUS1) ||
                     (req.addr == ADDR_STATUS2) ||
                     (req.addr == ADDR_ALARM1) ||
                     (req.addr == ADDR_ALARM2) ||
                     (req.addr == ADDR_CORR) ||
                     (req.addr == ADDR_STATE);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (req.addr)
            ADDR_STATUS1: begin
                rd_mux[S1_A1_FLAG] = alarm1_match_flag_q;
                rd_mux[S1_A2_FLAG] = alarm2_match_flag_q;
            end
            ADDR_STATUS2: rd_mux[S2_W-1:0] = status2_q;
            ADDR_ALARM1: rd_mux[SET_W-1:0] = alarm1_setting_reg_q;
            ADDR_ALARM2: rd_mux[SET_W-1:0] = alarm2_setting_reg_q;
            ADDR_CORR: rd_mux[CORR_W-1:0] = corr_q;
            ADDR_STATE: begin
                rd_mux[5:0] = sec_q;
                rd_mux[8] = pin_oe_q;
                rd_mux[9] = edge_active;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_q <= '0;
        end else if (req.sel && req.en && !rsp_q.ready) begin
            rsp_q.ready <= 1'b1;
            rsp_q.slverr <= !addr_ok;
            rsp_q.rdata <= req.wr ? 32'h0000_0000 : rd_mux;
        end else begin
            rsp_q <= '0;
        end
    end

    assign prdata = rsp_q.rdata;
    assign pready = rsp_q.ready;
    assign pslverr = rsp_q.slverr;

    // ------------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status2_q <= STATUS2_RST;
            alarm1_setting_reg_q <= SETTING_RST;
            alarm2_setting_reg_q <= SETTING_RST;
            corr_q <= CORR_RST;
        end else if (acc_wr) begin
            case (req.addr)
                ADDR_STATUS2: status2_q <= req.wdata[S2_W-1:0];
                ADDR_ALARM1: alarm1_setting_reg_q <= req.wdata[SET_W-1:0];
                ADDR_ALARM2: alarm2_setting_reg_q <= req.wdata[SET_W-1:0];
                ADDR_CORR: corr_q <= req.wdata[CORR_W-1:0];
                default: status2_q <= status2_q;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // time base: fractional divider gives the 32.768 kHz tick enable
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q <= '0;
            osc_tick_q <= 1'b0;
        end else if ({8'h00, acc_q} + OSC_INC >= CLK_MOD) begin
            acc_q <= ACC_W'({8'h00, acc_q} + OSC_INC - CLK_MOD);
            osc_tick_q <= 1'b1;
        end else begin
            acc_q <= ACC_W'({8'h00, acc_q} + OSC_INC);
            osc_tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // second divider with rate trim
    // ------------------------------------------------------------------
    // the register holds the code bit-reversed: b1 is its top bit
    assign corr_code = {corr_q[1], corr_q[2], corr_q[3], corr_q[4],
                        corr_q[5], corr_q[6], corr_q[7]};
    // the last second of each 20 s or 60 s interval is the trim point;
    // a fixed point keeps the 1 Hz output clean in the other seconds
    assign corr_second = corr_q[0] ? (sec_q == SEC_LAST) :
        ((sec_q == CORR_SHORT_LAST) || (sec_q == 6'(2 * CORR_SHORT_S - 1))
         || (sec_q == SEC_LAST));
    // one code step is two oscillator counts, i.e. one count of the
    // 16384 Hz stage: 2/655360 = 3.052 ppm, 2/1966080 = 1.017 ppm;
    // the code is signed, +63 shortens, -64 lengthens the second
    always_comb begin
        div_term = DIV_TERM;
        if (corr_second && corr_code != 7'h00) begin
            div_term = DIV_W'(DIV_TERM - {{8{corr_code[6]}},
                                          corr_code, 1'b0});
        end
    end

    assign carry_now = osc_tick_q && (div_q >= div_term) &&
                       (sec_q == SEC_LAST);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= '0;
            sec_q <= '0;
        end else if (osc_tick_q) begin
            if (div_q >= div_term) begin
                div_q <= '0;
                sec_q <= (sec_q == SEC_LAST) ? 6'h00 : sec_q + 6'h01;
            end else begin
                div_q <= div_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            minute_carry_q <= 1'b0;
            second_tick_q <= 1'b0;
        end else begin
            minute_carry_q <= carry_now;
            second_tick_q <= osc_tick_q && (div_q >= div_term);
        end
    end

    assign minute_carry = minute_carry_q;
    assign second_tick = second_tick_q;

    // edge_active stays set for 7.81 ms after each minute carry
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            edge_cnt_q <= '0;
        end else if (carry_now) begin
            edge_cnt_q <= EDGE_W'(EDGE_LEN);
        end else if (edge_cnt_q != '0) begin
            edge_cnt_q <= edge_cnt_q - 17'h00001;
        end
    end

    assign edge_active = (edge_cnt_q != '0);

    // ------------------------------------------------------------------
    // alarm compare
    // ------------------------------------------------------------------
    assign alarm1_match =
        (alarm1_setting_reg_q == SET_W'(time_now));
    assign alarm2_match =
        (alarm2_setting_reg_q == SET_W'(time_now));

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm1_match_q <= 1'b0;
            alarm2_match_q <= 1'b0;
        end else begin
            alarm1_match_q <= alarm1_match;
            alarm2_match_q <= alarm2_match;
        end
    end

    // only the start of a match, or a minute count during one, fires;
    // toggling the enable alone inside the match stays quiet
    assign alarm2_event = (mode == RAT_MODE_ALARM2) && alarm2_match &&
        (!alarm2_match_q || minute_carry_q);

    // set wins over a clear; a read clears only the flags it returned
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm1_match_flag_q <= 1'b0;
        end else if (status2_q[S2_A1_EN] && alarm1_match &&
                     !alarm1_match_q) begin
            alarm1_match_flag_q <= 1'b1;
        end else if (acc_rd && req.addr == ADDR_STATUS1 &&
                     rsp_q.rdata[S1_A1_FLAG]) begin
            alarm1_match_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm2_match_flag_q <= 1'b0;
        end else if (alarm2_event) begin
            alarm2_match_flag_q <= 1'b1;
        end else if (acc_rd && req.addr == ADDR_STATUS1 &&
                     rsp_q.rdata[S1_A2_FLAG]) begin
            alarm2_match_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm2_low_q <= 1'b0;
        end else if (mode != RAT_MODE_ALARM2) begin
            alarm2_low_q <= 1'b0;
        end else if (alarm2_event) begin
            alarm2_low_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // pin mode decode
    // ------------------------------------------------------------------
    // edge mode ignores the alarm 2 enable; frequency enable wins
    always_comb begin
        if (status2_q[S2_FE]) begin
            mode = RAT_MODE_FREQ;
        end else if (status2_q[S2_ME]) begin
            mode = RAT_MODE_EDGE;
        end else if (status2_q[S2_MP]) begin
            mode = RAT_MODE_PERIOD;
        end else if (status2_q[S2_A2_OE]) begin
            mode = RAT_MODE_ALARM2;
        end else begin
            mode = RAT_MODE_OFF;
        end
    end

    // ------------------------------------------------------------------
    // user frequency: b7 = 1 Hz down to b3 = 16 Hz, from divider bits
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < FSEL_N; gi++) begin : g_freq
            assign freq_src[gi] = div_q[14 - gi];
            assign freq_sel[gi] = alarm2_setting_reg_q[FSEL_LO + 4 - gi];
        end
    endgenerate

    // empty selection keeps the pin released
    assign freq_low = (|freq_sel) && (&(freq_src | ~freq_sel));

    // ------------------------------------------------------------------
    // per-minute edge and minute-periodical modes
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            edge_latch_q <= 1'b0;
        end else if (mode != RAT_MODE_EDGE) begin
            edge_latch_q <= 1'b0;
        end else if (edge_active) begin
            edge_latch_q <= 1'b1;
        end
    end

    // the run state survives a short disable, so re-enabling during the
    // low half resumes it; a carry seen while disabled ends it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            period_run_q <= 1'b0;
        end else if (carry_now) begin
            period_run_q <= (mode == RAT_MODE_PERIOD);
        end
    end

    always_comb begin
        case (mode)
            RAT_MODE_ALARM2: pin_low = alarm2_low_q;
            RAT_MODE_FREQ: pin_low = freq_low;
            RAT_MODE_EDGE: pin_low = edge_latch_q || edge_active;
            RAT_MODE_PERIOD: pin_low = period_run_q &&
                                       (sec_q < SEC_HALF);
            default: pin_low = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // open-drain pin: only ever pulls low
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_oe_q <= 1'b0;
        end else begin
            pin_oe_q <= pin_low;
        end
    end

    assign second_irq_pin_o = 1'b0;
    assign second_irq_pin_oe = pin_oe_q;

endmodule : rat_top

/* test/rat_top_sva.sv */
// checker: apb timing, alarm 2 pin behaviour and second tick spacing
module rat_top_sva #(
    parameter int unsigned OSC_INC = 32768,
    parameter int unsigned CLK_MOD = 10000000,
    parameter int unsigned EDGE_LEN = 78100
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // calendar side and pin
    input rat_pkg::rat_time_t time_now,
    input wire logic minute_carry,
    input wire logic second_tick,
    input wire logic second_irq_pin_o,
    input wire logic second_irq_pin_oe
);
    import rat_pkg::*;
    // --------------------------------------------------------------
    // shadows of the mode and alarm 2 registers
    // --------------------------------------------------------------
    // trim moves one second by at most 128 ticks; 2 clk slack for rounding
    localparam longint TMIN = (longint'(32640) * CLK_MOD) / OSC_INC - 2;
    localparam longint TMAX = (longint'(32896) * CLK_MOD) / OSC_INC + 2;
    logic [4:0] s2_q;
    logic [18:0] a2_q;
    logic match_q;
    logic seen_q;
    logic [31:0] cnt_q;
    wire logic wr_ok = psel && penable && pready && pwrite;
    wire logic match = time_now == a2_q;
    wire logic a2m = s2_q[S2_A2_OE] && s2_q[4:2] == 3'h0;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s2_q <= 5'h00;
            a2_q <= 19'h00000;
        end else if (wr_ok && paddr == ADDR_STATUS2) begin
            s2_q <= pwdata[4:0];
        end else if (wr_ok && paddr == ADDR_ALARM2) begin
            a2_q <= pwdata[18:0];
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            match_q <= 1'b0;
            seen_q <= 1'b0;
            cnt_q <= 32'h0;
        end else begin
            match_q <= match;
            seen_q <= seen_q | second_tick;
            cnt_q <= second_tick ? 32'h1 : cnt_q + 32'h1;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    // --------------------------------------------------------------
    // properties
    // --------------------------------------------------------------
    AST_APB_WAIT: assert property (
        psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    AST_APB_PULSE: assert property (
        pready |=> !pready) else $error("pready longer than one cycle");
    AST_REFUSE: assert property (
        psel && penable && pready && paddr > ADDR_STATE |->
        pslverr && prdata == 32'h0) else $error("unmapped not refused");
    AST_S1_FIELDS: assert property (
        pready && !pwrite && paddr == ADDR_STATUS1 |->
        prdata[31:4] == 28'h0 && prdata[1:0] == 2'h0)
        else $error("status 1 stray bits");
    AST_A2_FIRE: assert property (
        a2m && match && !match_q |->
        ##[1:3] (second_irq_pin_oe && !second_irq_pin_o || !a2m || !match))
        else $error("alarm 2 match did not pull the pin");
    AST_A2_RELEASE: assert property (
        wr_ok && paddr == ADDR_STATUS2 && pwdata[4:1] == 4'h0 |->
        ##[1:3] !second_irq_pin_oe) else $error("pin not released");
    AST_FREQ_NONE: assert property (
        (s2_q[S2_FE] && a2_q[7:3] == 5'h00) [*3] |-> !second_irq_pin_oe)
        else $error("frequency mode with no select drives pin");
    AST_TICK_SPAN: assert property (
        second_tick && seen_q |-> cnt_q >= TMIN && cnt_q <= TMAX)
        else $error("second length out of trim span");
endmodule : rat_top_sva

bind rat_top rat_top_sva #(.OSC_INC(OSC_INC), .CLK_MOD(CLK_MOD),
    .EDGE_LEN(EDGE_LEN)) rat_top_sva_inst (.sys_clk(sys_clk),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .time_now(time_now), .minute_carry(minute_carry),
    .second_tick(second_tick), .second_irq_pin_o(second_irq_pin_o),
    .second_irq_pin_oe(second_irq_pin_oe));

/* test/rat_cal_model.sv */
// far side model: calendar time source and pull-up on the interrupt pin
module rat_cal_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // time load from the bench
    input wire logic load,
    input rat_pkg::rat_time_t load_time,
    // design side
    input wire logic minute_carry,
    input wire logic second_irq_pin_oe,
    output rat_pkg::rat_time_t time_now,
    output logic pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    import rat_pkg::*;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            time_now <= '0;
        end else if (load) begin
            time_now <= load_time;
        end else if (minute_carry) begin
            time_now.minute <= time_now.minute + 8'h01;
        end
    end
    // open drain: a released pin is pulled high, never left floating
    assign pin_level = second_irq_pin_oe ? 1'b0 : 1'b1;
endmodule : rat_cal_model

/* test/rat_top_tb_top.sv */
// testbench: registers, alarms, pin modes and second length
module rat_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rat_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, minute_carry, second_tick, pin_oe, pin_level;
    logic load = 1'b0;
    logic tick_done = 1'b0;
    rat_time_t time_now;
    rat_time_t load_time = '0;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    integer seed = 32'h3C14A07F;

    always #50 sys_clk = ~sys_clk;

    rat_top #(.OSC_INC(CLK_HZ), .EDGE_LEN(20)) rat_top_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .time_now(time_now),
        .minute_carry(minute_carry), .second_tick(second_tick),
        .second_irq_pin_o(), .second_irq_pin_oe(pin_oe));
    rat_cal_model rat_cal_model_inst (.sys_clk(sys_clk), .arst_n(arst_n),
        .load(load), .load_time(load_time), .minute_carry(minute_carry),
        .second_irq_pin_oe(pin_oe), .time_now(time_now),
        .pin_level(pin_level));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic wrap_up;
        if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, exp);
    endtask : rd
    task automatic set_time(input rat_time_t v);
        @(posedge sys_clk);
        load <= 1'b1;
        load_time <= v;
        @(posedge sys_clk);
        load <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : set_time
    task automatic pin_is(input logic x);
        repeat (3) @(posedge sys_clk);
        check({31'h0, pin_level}, {31'h0, x});
    endtask : pin_is
    task automatic count_low(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge sys_clk);
            if (pin_level === 1'b0) c++;
        end
    endtask : count_low
    // software side: fast clock 128 minus ratio, slow ratio plus one
    function automatic logic [7:0] corr_code(input logic fast, input int r,
            input logic b0);
        logic [6:0] c;
        logic [6:0] rv;
        c = fast ? 7'(128 - r) : 7'(r + 1);
        for (int i = 0; i < 7; i++) rv[i] = c[6 - i];
        return {rv, b0};
    endfunction : corr_code
    // selected square waves of 16 and 8 Hz: low share halves per select
    function automatic int exp_low(input logic [4:0] s);
        return 4096 >> $countones(s);
    endfunction : exp_low

    // ----------------------------------------------------------------
    // second length and timeout
    // ----------------------------------------------------------------
    initial begin : tick_meas
        int n;
        @(posedge arst_n);
        @(posedge sys_clk iff second_tick === 1'b1);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (second_tick !== 1'b1);
        check(32'(n), 32'h8000);
        tick_done = 1'b1;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: timeout", $time);
            wrap_up();
        end
    end

    initial begin : main
        int c;
        logic [31:0] q;
        logic e;
        rat_time_t t;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int a = 0; a <= 16; a += 4) rd(8'(a), 32'h0);
        apb(1'b0, 8'h18, 32'h0, q, e);
        check({q[30:0], e}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            q = {24'h0, corr_code(i[0], $unsigned($random(seed)) % 63, i[1])};
            wr(ADDR_CORR, q);
            rd(ADDR_CORR, q);
        end
        wr(ADDR_CORR, 32'h0);
        // alarm 1: a day mismatch must not set the flag
        t = rat_time_t'($random(seed));
        t.minute[0] = 1'b1;
        wr(ADDR_ALARM1, {13'h0, t});
        wr(ADDR_STATUS2, 32'h1);
        set_time({t.dow + 3'h1, t.hour, t.minute});
        rd(ADDR_STATUS1, 32'h0);
        set_time(t);
        rd(ADDR_STATUS1, 32'h8);
        rd(ADDR_STATUS1, 32'h0);
        // alarm 2: fire, clear flag, release, re-enable inside match
        t = rat_time_t'($random(seed));
        t.minute[0] = 1'b0;
        wr(ADDR_ALARM2, 32'h0);
        wr(ADDR_ALARM2, {13'h0, t});
        wr(ADDR_STATUS2, 32'h2);
        set_time(t);
        pin_is(1'b0);
        rd(ADDR_STATUS1, 32'h4);
        rd(ADDR_STATUS1, 32'h0);
        pin_is(1'b0);
        wr(ADDR_STATUS2, 32'h0);
        pin_is(1'b1);
        wr(ADDR_STATUS2, 32'h2);
        pin_is(1'b1);
        rd(ADDR_STATUS1, 32'h0);
        wr(ADDR_STATUS2, 32'h0);
        wr(ADDR_ALARM2, 32'h0);
        // frequency mode outranks the alarm 2 enable
        wr(ADDR_STATUS2, 32'hA);
        pin_is(1'b1);
        for (int i = 1; i < 4; i++) begin
            wr(ADDR_ALARM2, {24'h0, 5'(i), 3'h0});
            repeat (4) @(posedge sys_clk);
            count_low(4096, c);
            check(32'(c), 32'(exp_low(5'(i))));
        end
        wr(ADDR_STATUS2, 32'h0);
        wr(ADDR_ALARM2, 32'h0);
        // edge and periodical modes stay released until a minute carry
        wr(ADDR_STATUS2, 32'h6);
        count_low(300, c);
        check(32'(c), 32'h0);
        wr(ADDR_STATUS2, 32'h10);
        count_low(300, c);
        check(32'(c), 32'h0);
        wr(ADDR_STATUS2, 32'h0);
        wait (tick_done === 1'b1);
        check({13'h0, time_now}, {13'h0, t});
        wrap_up();
    end
endmodule : rat_top_tb_top
